// ---- core/hcrb_defs.vh ----
`ifndef HCRB_DEFS_VH
`define HCRB_DEFS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define HCRB_OFF_REVISION 8'h00
`define HCRB_OFF_SRC_LEVEL 8'h01
`define HCRB_OFF_OVDIS 8'h02
`define HCRB_OFF_OVCH 8'h03
`define HCRB_OFF_COLD 8'h04
`define HCRB_OFF_HOT 8'h05
`define HCRB_OFF_POWER 8'h06
`define HCRB_OFF_IDLE 8'h07
`define HCRB_OFF_SAMPLE 8'h08
`define HCRB_OFF_METER 8'h09
`define HCRB_OFF_IRQ_EN 8'h0A
`define HCRB_OFF_APPLY 8'h0B
`define HCRB_OFF_FLAGS 8'h0C
`define HCRB_OFF_STATE 8'h0D
`define HCRB_OFF_METER0 8'h0E
`define HCRB_OFF_METER1 8'h0F
`define HCRB_OFF_METER2 8'h10
`define HCRB_OFF_THERMAL 8'h11
`define HCRB_OFF_BATTERY 8'h12
`define HCRB_OFF_HARVEST 8'h13

// ----------------------------------------
// Reset values
// ----------------------------------------
`define HCRB_RST_SRC_LEVEL 7'h77
`define HCRB_RST_OVDIS 6'h2D
`define HCRB_RST_OVCH 6'h33
`define HCRB_RST_COLD 8'h8F
`define HCRB_RST_HOT 8'h2F
`define HCRB_RST_POWER 4'h7
`define HCRB_RST_IDLE 1'h1
`define HCRB_RST_SAMPLE 3'h0
`define HCRB_RST_METER 4'h0
`define HCRB_RST_IRQ_EN 6'h01

// ----------------------------------------
// Field positions
// ----------------------------------------
`define HCRB_BIT_HIGH_POWER 1
`define HCRB_BIT_APPLY 0
`define HCRB_BIT_APPLY_BUSY 2
`define HCRB_BIT_READY_EVENT 0
`define HCRB_IDLE_CODE 7'h0C

// ----------------------------------------
// Bus address
// ----------------------------------------
`define HCRB_BUS_ADDR_BASE 7'h40

// ----------------------------------------
// Regulation voltage, units of 100 uV
// ----------------------------------------
`define HCRB_REG_LOW_OFFSET 14'h00E1
`define HCRB_REG_LOW_STEP 14'h004B
`define HCRB_REG_LOW_LAST 7'h25
`define HCRB_REG_HIGH_STEP 14'h0096
`define HCRB_REG_HIGH_OFFSET 14'h09F6
`define HCRB_REG_SAT_CODE 7'h73
`define HCRB_REG_SAT_VALUE 14'h396C

// ----------------------------------------
// Storage thresholds, units of 10 uV
// ----------------------------------------
`define HCRB_THR_STEP 19'h015F9
`define HCRB_OVDIS_OFFSET 19'h0C5C1
`define HCRB_OVDIS_FLOOR 19'h445C0
`define HCRB_OVCH_OFFSET 19'h1E366
`define HCRB_OVCH_FLOOR 19'h493E0

`endif

// ---- core/hcrb_sync.v ----
`timescale 1ns/1ps
module hcrb_sync (
	// Clock and reset
	input wire clk,
	input wire rst_n,
	// Asynchronous levels: clock line, data line, strap
	input wire [2:0] asyncIn,
	// Synchronised levels
	output reg [2:0] syncOut
);
	reg [2:0] stage_q;

	// Idle bus lines are high, so reset to high to avoid a false start
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stage_q <= 3'h7;
			syncOut <= 3'h7;
		end else begin
			stage_q <= asyncIn;
			syncOut <= stage_q;
		end
	end
endmodule // hcrb_sync

// ---- core/hcrb_register_bank.v ----
`timescale 1ns/1ps
`include "hcrb_defs.vh"
module hcrb_register_bank #(
	parameter HIGH_POWER_VARIANT = 1,
	parameter [7:0] CHIP_REVISION = 8'h10 // Arbitrary value
) (
	// Clock and reset
	input wire clk,
	input wire rst_n,
	// Serial bus pins
	input wire sclIn,
	input wire sdaIn,
	output reg sdaOut,
	output reg sdaOe_n,
	// Address strap pin
	input wire addrStrap,
	// Events and state from the charger core
	input wire [5:1] eventPulse,
	input wire [6:0] monitorState,
	input wire [23:0] meterValue,
	input wire [7:0] thermalValue,
	input wire [7:0] batteryValue,
	input wire [7:0] harvesterValue,
	// Active configuration
	output reg [6:0] activeSrcLevel,
	output reg [5:0] activeOvdis,
	output reg [5:0] activeOvch,
	output reg [7:0] activeCold,
	output reg [7:0] activeHot,
	output reg [3:0] activePower,
	output reg activeIdleEn,
	output reg [2:0] activeSampleRate,
	output reg [3:0] activeMeterCtrl,
	// Derived outputs
	output reg idleState,
	output reg [13:0] srcRegVoltage,
	output reg [18:0] ovdisVoltage,
	output reg [18:0] ovchVoltage,
	output reg irqOut
);
	// ----------------------------------------
	// Bus states
	// ----------------------------------------
	localparam [2:0] ST_IDLE = 3'h0;
	localparam [2:0] ST_ADDR = 3'h1;
	localparam [2:0] ST_ACK = 3'h2;
	localparam [2:0] ST_WRITE = 3'h3;
	localparam [2:0] ST_READ = 3'h4;
	localparam [2:0] ST_RACK = 3'h5;

	// ----------------------------------------
	// Conversion functions
	// ----------------------------------------
	function [13:0] regVolt;
		input [6:0] code;
		reg [13:0] wide;
		begin
			wide = {7'h00, code};
			if (code >= `HCRB_REG_SAT_CODE)
				regVolt = `HCRB_REG_SAT_VALUE;
			else if (code > `HCRB_REG_LOW_LAST)
				regVolt = wide * `HCRB_REG_HIGH_STEP - `HCRB_REG_HIGH_OFFSET;
			else
				regVolt = `HCRB_REG_LOW_OFFSET + wide * `HCRB_REG_LOW_STEP;
		end
	endfunction

	function [18:0] thrVolt;
		input [5:0] code;
		input [18:0] offset;
		input [18:0] floor;
		reg [18:0] raw;
		begin
			raw = offset + {13'h0000, code} * `HCRB_THR_STEP;
			thrVolt = (raw < floor) ? floor : raw;
		end
	endfunction

	// ----------------------------------------
	// Pin synchronisers and edges
	// ----------------------------------------
	wire [2:0] pinSync;
	wire scl = pinSync[0];
	wire sda = pinSync[1];
	reg sclPrev_q;
	reg sdaPrev_q;

	hcrb_sync uSync (
		.clk(clk),
		.rst_n(rst_n),
		.asyncIn({addrStrap, sdaIn, sclIn}),
		.syncOut(pinSync)
	);

	wire sclRise = scl & ~sclPrev_q;
	wire sclFall = ~scl & sclPrev_q;
	wire busStart = scl & sclPrev_q & sdaPrev_q & ~sda;
	wire busStop = scl & sclPrev_q & ~sdaPrev_q & sda;

	// ----------------------------------------
	// Written settings and status
	// ----------------------------------------
	reg [6:0] srcLevel_q;
	reg [5:0] ovdis_q;
	reg [5:0] ovch_q;
	reg [7:0] cold_q;
	reg [7:0] hot_q;
	reg [3:0] power_q;
	reg idleEn_q;
	reg [2:0] sampleRate_q;
	reg [3:0] meterCtrl_q;
	reg [5:0] interrupt_enables_q;
	reg [5:0] flags_q;
	reg applyReq_q;
	reg applyBusy_q;
	reg readyPending_q;
	reg strapTaken_q;
	reg [1:0] strapWait_q;
	reg [6:0] busAddr_q;

	// ----------------------------------------
	// Bus engine state
	// ----------------------------------------
	reg [2:0] state_q;
	reg [3:0] bitCnt_q;
	reg [7:0] shift_q;
	reg [7:0] pointer_q;
	reg havePointer_q;
	reg readMode_q;
	reg addrPhase_q;
	reg masterAck_q;
	reg [7:0] readData;

	// Power bit 1 is kept only on the variant that has it, apart from the reset value of activePower
	wire [3:0] powerMask = (HIGH_POWER_VARIANT != 0) ? 4'hF : 4'hD;
	wire flagReadDone = sclFall && (state_q == ST_READ) && (bitCnt_q == 4'h8)
		&& (pointer_q == `HCRB_OFF_FLAGS + 8'h01);
	wire writeStrobe = sclFall && (state_q == ST_WRITE) && (bitCnt_q == 4'h8)
		&& havePointer_q;

	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	always @* begin
		case (pointer_q)
			`HCRB_OFF_REVISION: readData = CHIP_REVISION;
			`HCRB_OFF_SRC_LEVEL: readData = {1'b0, srcLevel_q};
			`HCRB_OFF_OVDIS: readData = {2'h0, ovdis_q};
			`HCRB_OFF_OVCH: readData = {2'h0, ovch_q};
			`HCRB_OFF_COLD: readData = cold_q;
			`HCRB_OFF_HOT: readData = hot_q;
			`HCRB_OFF_POWER: readData = {4'h0, power_q & powerMask};
			`HCRB_OFF_IDLE: readData = {7'h00, idleEn_q};
			`HCRB_OFF_SAMPLE: readData = {5'h00, sampleRate_q};
			`HCRB_OFF_METER: readData = {4'h0, meterCtrl_q};
			`HCRB_OFF_IRQ_EN: readData = {2'h0, interrupt_enables_q};
			`HCRB_OFF_APPLY: readData = {5'h00, applyBusy_q, 1'b0, applyReq_q};
			`HCRB_OFF_FLAGS: readData = {2'h0, flags_q};
			`HCRB_OFF_STATE: readData = {1'b0, monitorState[6], 1'b0, monitorState[4:1], 1'b0};
			`HCRB_OFF_METER0: readData = meterValue[7:0];
			`HCRB_OFF_METER1: readData = meterValue[15:8];
			`HCRB_OFF_METER2: readData = meterValue[23:16];
			`HCRB_OFF_THERMAL: readData = thermalValue;
			`HCRB_OFF_BATTERY: readData = batteryValue;
			`HCRB_OFF_HARVEST: readData = harvesterValue;
			default: readData = 8'h00;
		endcase
	end

	// ----------------------------------------
	// Strap capture after reset release
	// ----------------------------------------
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			strapTaken_q <= 1'b0;
			strapWait_q <= 2'h0;
			busAddr_q <= `HCRB_BUS_ADDR_BASE;
		end else if (!strapTaken_q) begin
			strapWait_q <= strapWait_q + 2'h1;
			// The synchroniser shows its reset level for two edges after release
			if (strapWait_q == 2'h2) begin
				strapTaken_q <= 1'b1;
				busAddr_q <= `HCRB_BUS_ADDR_BASE | {6'h00, pinSync[2]};
			end
		end
	end

	// ----------------------------------------
	// Bus engine
	// ----------------------------------------
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sclPrev_q <= 1'b1;
			sdaPrev_q <= 1'b1;
			state_q <= ST_IDLE;
			bitCnt_q <= 4'h0;
			shift_q <= 8'h00;
			pointer_q <= 8'h00;
			havePointer_q <= 1'b0;
			readMode_q <= 1'b0;
			addrPhase_q <= 1'b0;
			masterAck_q <= 1'b0;
			sdaOut <= 1'b0;
			sdaOe_n <= 1'b1;
		end else begin
			sclPrev_q <= scl;
			sdaPrev_q <= sda;
			sdaOut <= 1'b0;
			if (busStart) begin
				state_q <= ST_ADDR;
				bitCnt_q <= 4'h0;
				sdaOe_n <= 1'b1;
			end else if (busStop) begin
				state_q <= ST_IDLE;
				sdaOe_n <= 1'b1;
			end else begin
				case (state_q)
					ST_ADDR, ST_WRITE: begin
						if (sclRise && bitCnt_q != 4'h8) begin
							shift_q <= {shift_q[6:0], sda};
							bitCnt_q <= bitCnt_q + 4'h1;
						end else if (sclFall && bitCnt_q == 4'h8) begin
							if (state_q == ST_ADDR) begin
								if (shift_q[7:1] == busAddr_q) begin
									readMode_q <= shift_q[0];
									havePointer_q <= havePointer_q & shift_q[0];
									addrPhase_q <= 1'b1;
									sdaOe_n <= 1'b0;
									state_q <= ST_ACK;
								end else begin
									state_q <= ST_IDLE;
								end
							end else begin
								if (!havePointer_q) begin
									pointer_q <= shift_q;
									havePointer_q <= 1'b1;
								end else begin
									pointer_q <= pointer_q + 8'h01;
								end
								addrPhase_q <= 1'b0;
								sdaOe_n <= 1'b0;
								state_q <= ST_ACK;
							end
						end
					end
					ST_ACK: begin
						if (sclFall) begin
							bitCnt_q <= 4'h0;
							if (readMode_q && addrPhase_q) begin
								shift_q <= {readData[6:0], 1'b0};
								sdaOe_n <= readData[7];
								pointer_q <= pointer_q + 8'h01;
								bitCnt_q <= 4'h1;
								state_q <= ST_READ;
							end else begin
								sdaOe_n <= 1'b1;
								state_q <= ST_WRITE;
							end
						end
					end
					ST_READ: begin
						if (sclFall) begin
							if (bitCnt_q == 4'h8) begin
								sdaOe_n <= 1'b1;
								state_q <= ST_RACK;
							end else begin
								sdaOe_n <= shift_q[7];
								shift_q <= {shift_q[6:0], 1'b0};
								bitCnt_q <= bitCnt_q + 4'h1;
							end
						end
					end
					ST_RACK: begin
						if (sclRise) begin
							masterAck_q <= ~sda;
						end else if (sclFall) begin
							if (masterAck_q) begin
								shift_q <= {readData[6:0], 1'b0};
								sdaOe_n <= readData[7];
								pointer_q <= pointer_q + 8'h01;
								bitCnt_q <= 4'h1;
								state_q <= ST_READ;
							end else begin
								state_q <= ST_IDLE;
							end
						end
					end
					default: begin
						sdaOe_n <= 1'b1;
					end
				endcase
			end
		end
	end

	// ----------------------------------------
	// Register writes
	// ----------------------------------------
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			srcLevel_q <= `HCRB_RST_SRC_LEVEL;
			ovdis_q <= `HCRB_RST_OVDIS;
			ovch_q <= `HCRB_RST_OVCH;
			cold_q <= `HCRB_RST_COLD;
			hot_q <= `HCRB_RST_HOT;
			power_q <= `HCRB_RST_POWER;
			idleEn_q <= `HCRB_RST_IDLE;
			sampleRate_q <= `HCRB_RST_SAMPLE;
			meterCtrl_q <= `HCRB_RST_METER;
			interrupt_enables_q <= `HCRB_RST_IRQ_EN;
			applyReq_q <= 1'b0;
		end else if (writeStrobe) begin
			// Offsets not listed, and read-only ones, take no write
			case (pointer_q)
				`HCRB_OFF_SRC_LEVEL: srcLevel_q <= shift_q[6:0];
				`HCRB_OFF_OVDIS: ovdis_q <= shift_q[5:0];
				`HCRB_OFF_OVCH: ovch_q <= shift_q[5:0];
				`HCRB_OFF_COLD: cold_q <= shift_q;
				`HCRB_OFF_HOT: hot_q <= shift_q;
				`HCRB_OFF_POWER: power_q <= (shift_q[3:0] & powerMask)
					| (power_q & ~powerMask);
				`HCRB_OFF_IDLE: idleEn_q <= shift_q[0];
				`HCRB_OFF_SAMPLE: sampleRate_q <= shift_q[2:0];
				`HCRB_OFF_METER: meterCtrl_q <= shift_q[3:0];
				`HCRB_OFF_IRQ_EN: interrupt_enables_q <= shift_q[5:0];
				`HCRB_OFF_APPLY: applyReq_q <= shift_q[`HCRB_BIT_APPLY];
				default: ;
			endcase
		end else if (applyBusy_q) begin
			applyReq_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// Apply written settings
	// ----------------------------------------
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			applyBusy_q <= 1'b0;
			activeSrcLevel <= `HCRB_RST_SRC_LEVEL;
			activeOvdis <= `HCRB_RST_OVDIS;
			activeOvch <= `HCRB_RST_OVCH;
			activeCold <= `HCRB_RST_COLD;
			activeHot <= `HCRB_RST_HOT;
			activePower <= `HCRB_RST_POWER;
			activeIdleEn <= `HCRB_RST_IDLE;
			activeSampleRate <= `HCRB_RST_SAMPLE;
			activeMeterCtrl <= `HCRB_RST_METER;
		end else begin
			// Busy covers the cycle between the request and the copy
			applyBusy_q <= applyReq_q & ~applyBusy_q;
			if (applyBusy_q) begin
				activeSrcLevel <= srcLevel_q;
				activeOvdis <= ovdis_q;
				activeOvch <= ovch_q;
				activeCold <= cold_q;
				activeHot <= hot_q;
				activePower <= power_q & powerMask;
				activeIdleEn <= idleEn_q;
				activeSampleRate <= sampleRate_q;
				activeMeterCtrl <= meterCtrl_q;
			end
		end
	end

	// ----------------------------------------
	// Derived settings
	// ----------------------------------------
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			idleState <= 1'b0;
			srcRegVoltage <= `HCRB_REG_SAT_VALUE;
			ovdisVoltage <= `HCRB_OVDIS_FLOOR;
			ovchVoltage <= `HCRB_OVCH_FLOOR;
		end else begin
			idleState <= activeIdleEn && (activeSrcLevel == `HCRB_IDLE_CODE);
			srcRegVoltage <= regVolt(activeSrcLevel);
			ovdisVoltage <= thrVolt(activeOvdis, `HCRB_OVDIS_OFFSET, `HCRB_OVDIS_FLOOR);
			ovchVoltage <= thrVolt(activeOvch, `HCRB_OVCH_OFFSET, `HCRB_OVCH_FLOOR);
		end
	end

	// ----------------------------------------
	// Event flags and interrupt
	// ----------------------------------------
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			readyPending_q <= 1'b1;
			flags_q <= 6'h00;
			irqOut <= 1'b0;
		end else begin
			readyPending_q <= 1'b0;
			// A set in the same cycle as the clearing read wins
			flags_q <= (flagReadDone ? 6'h00 : flags_q)
				| {eventPulse, readyPending_q};
			irqOut <= |(flags_q & interrupt_enables_q);
		end
	end
endmodule // hcrb_register_bank

// ---- verif/hcrb_register_bank_props.sv ----
`timescale 1ns/1ps
`include "hcrb_defs.vh"
module hcrb_register_bank_props (
	// Clock and reset
	input wire clk,
	input wire rst_n,
	// Applied settings
	input wire [6:0] activeSrcLevel,
	input wire [5:0] activeOvdis,
	input wire [5:0] activeOvch,
	input wire activeIdleEn,
	// Derived outputs
	input wire idleState,
	input wire [13:0] srcRegVoltage,
	input wire [18:0] ovdisVoltage,
	input wire [18:0] ovchVoltage,
	input wire irqOut
);
	// ----------------------------------------
	// Expected derived values
	// ----------------------------------------
	// Upper range wraps in 14 bits before the subtraction; the result still fits
	wire [13:0] srcExp;
	wire [18:0] ovdisRaw;
	wire [18:0] ovchRaw;
	wire [18:0] ovdisExp;
	wire [18:0] ovchExp;
	wire idleCond;
	assign srcExp = (activeSrcLevel >= `HCRB_REG_SAT_CODE) ? `HCRB_REG_SAT_VALUE :
		(activeSrcLevel <= `HCRB_REG_LOW_LAST) ?
		`HCRB_REG_LOW_OFFSET + `HCRB_REG_LOW_STEP * activeSrcLevel :
		`HCRB_REG_HIGH_STEP * activeSrcLevel - `HCRB_REG_HIGH_OFFSET;
	assign ovdisRaw = `HCRB_OVDIS_OFFSET + `HCRB_THR_STEP * activeOvdis;
	assign ovchRaw = `HCRB_OVCH_OFFSET + `HCRB_THR_STEP * activeOvch;
	assign ovdisExp = (ovdisRaw < `HCRB_OVDIS_FLOOR) ? `HCRB_OVDIS_FLOOR : ovdisRaw;
	assign ovchExp = (ovchRaw < `HCRB_OVCH_FLOOR) ? `HCRB_OVCH_FLOOR : ovchRaw;
	assign idleCond = activeIdleEn && (activeSrcLevel == `HCRB_IDLE_CODE);

	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	// ----------------------------------------
	// Properties
	// ----------------------------------------
	reg_low_map_a: assert property (
		activeSrcLevel <= `HCRB_REG_LOW_LAST |=> srcRegVoltage == $past(srcExp))
		else $error("low range regulation voltage wrong");
	reg_high_map_a: assert property (
		activeSrcLevel > `HCRB_REG_LOW_LAST && activeSrcLevel < `HCRB_REG_SAT_CODE
		|=> srcRegVoltage == $past(srcExp))
		else $error("high range regulation voltage wrong");
	reg_saturate_a: assert property (
		activeSrcLevel >= `HCRB_REG_SAT_CODE |=> srcRegVoltage == `HCRB_REG_SAT_VALUE)
		else $error("regulation voltage not saturated");
	idle_entry_a: assert property (
		1'b1 |=> idleState == $past(idleCond))
		else $error("idle state does not follow code and enable");
	ovdis_floor_a: assert property (
		1'b1 |=> ovdisVoltage == $past(ovdisExp))
		else $error("overdischarge level wrong");
	ovch_floor_a: assert property (
		1'b1 |=> ovchVoltage == $past(ovchExp))
		else $error("overcharge level wrong");
	ready_irq_a: assert property (
		$rose(rst_n) |-> ##[1:3] irqOut)
		else $error("ready interrupt missing after reset");
	reset_settings_a: assert property (
		$rose(rst_n) |-> activeSrcLevel == `HCRB_RST_SRC_LEVEL
		&& activeOvdis == `HCRB_RST_OVDIS && activeOvch == `HCRB_RST_OVCH)
		else $error("applied settings not at reset values");
endmodule // hcrb_register_bank_props

bind hcrb_register_bank hcrb_register_bank_props props_u (.clk(clk), .rst_n(rst_n),
	.activeSrcLevel(activeSrcLevel), .activeOvdis(activeOvdis), .activeOvch(activeOvch),
	.activeIdleEn(activeIdleEn), .idleState(idleState), .srcRegVoltage(srcRegVoltage),
	.ovdisVoltage(ovdisVoltage), .ovchVoltage(ovchVoltage), .irqOut(irqOut));

// ---- verif/hcrb_host_model.sv ----
`timescale 1ns/1ps
module hcrb_host_model (
	// Clock
	input wire clk,
	// Device drive enable, active low
	input wire sdaOe_n,
	// Bus lines as seen on the wire
	output wire sclLine,
	output wire sdaLine
);
	reg sclHigh_q;
	reg sdaLow_q;
	// Clock stands high between frames; data is open drain with a pull-up
	assign sclLine = sclHigh_q;
	assign sdaLine = ~sdaLow_q & sdaOe_n;
	initial begin
		sclHigh_q = 1'b1;
		sdaLow_q = 1'b0;
	end
	task quarter;
		repeat (4) @(posedge clk);
	endtask
	// Data changes mid-low, sampled mid-high, well clear of the device's 3 clk lag
	task busBit(input b, output r);
		begin
			quarter;
			sdaLow_q <= ~b;
			quarter;
			sclHigh_q <= 1'b1;
			quarter;
			r = sdaLine;
			quarter;
			sclHigh_q <= 1'b0;
		end
	endtask
	task startBit;
		begin
			quarter;
			sdaLow_q <= 1'b0;
			quarter;
			sclHigh_q <= 1'b1;
			quarter;
			sdaLow_q <= 1'b1;
			quarter;
			sclHigh_q <= 1'b0;
		end
	endtask
	task stopBit;
		begin
			quarter;
			sdaLow_q <= 1'b1;
			quarter;
			sclHigh_q <= 1'b1;
			quarter;
			sdaLow_q <= 1'b0;
			quarter;
		end
	endtask
	task byteXfer(input [7:0] tx, input ackBit, output [7:0] rx, output acked);
		reg a;
		integer i;
		begin
			for (i = 7; i >= 0; i--) busBit(tx[i], rx[i]);
			busBit(ackBit, a);
			acked = ~a;
		end
	endtask
endmodule // hcrb_host_model

// ---- verif/hcrb_register_bank_test.sv ----
`timescale 1ns/1ps
`include "hcrb_defs.vh"
module hcrb_register_bank_test;
	localparam [7:0] REV = 8'h10; // Arbitrary value
	localparam [6:0] BUS_ADDR = `HCRB_BUS_ADDR_BASE | 7'h01;
	localparam [159:0] RST_TAB = {REV, 8'h77, 8'h2D, 8'h33, 8'h8F, 8'h2F, 8'h07, 8'h01,
		8'h00, 8'h00, 8'h01, 8'h00, 8'h01, 8'h5E, 8'h81, 8'hC3, 8'hA5, 8'h3C, 8'hC4, 8'h96};
	localparam [167:0] CFG_TAB = {24'h0C3F05, 24'h0D0033, 24'h252D3F, 24'h26041F,
		24'h722920, 24'h730000, 24'hFFFFFF};
	localparam [47:0] RO_OFF = {8'h00, 8'h0C, 8'h0D, 8'h0E, 8'h13, 8'h20};
	localparam [47:0] RO_EXP = {REV, 8'h00, 8'h5E, 8'h81, 8'h96, 8'h00};
	reg clk;
	reg rst_n;
	reg addrStrap;
	reg [5:1] eventPulse;
	reg [6:0] monitorState;
	wire sclIn, sdaIn, sdaOe_n, idleState, irqOut, activeIdleEn;
	wire [6:0] activeSrcLevel;
	wire [5:0] activeOvdis, activeOvch;
	wire sdaOut;
	wire [7:0] activeCold, activeHot;
	wire [3:0] activePower, activeMeterCtrl;
	wire [2:0] activeSampleRate;
	wire [13:0] srcRegVoltage;
	wire [18:0] ovdisVoltage, ovchVoltage;
	integer failures, nTests, i, k;
	logic [7:0] wrBuf[$];
	logic [7:0] rdBuf[0:31];
	logic [7:0] rx;
	logic ack;
	logic [23:0] cfg;
	logic [6:0] prevSrc;

	hcrb_register_bank #(.HIGH_POWER_VARIANT(1), .CHIP_REVISION(REV)) dut_u (.clk(clk),
		.rst_n(rst_n), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe_n(sdaOe_n),
		.addrStrap(addrStrap), .eventPulse(eventPulse), .monitorState(monitorState),
		.meterValue(24'hA5C381), .thermalValue(8'h3C), .batteryValue(8'hC4),
		.harvesterValue(8'h96), .activeSrcLevel(activeSrcLevel), .activeOvdis(activeOvdis),
		.activeOvch(activeOvch), .activeCold(activeCold), .activeHot(activeHot),
		.activePower(activePower), .activeIdleEn(activeIdleEn),
		.activeSampleRate(activeSampleRate), .activeMeterCtrl(activeMeterCtrl),
		.idleState(idleState), .srcRegVoltage(srcRegVoltage), .ovdisVoltage(ovdisVoltage),
		.ovchVoltage(ovchVoltage), .irqOut(irqOut));
	hcrb_host_model host_u (.clk(clk), .sdaOe_n(sdaOe_n), .sclLine(sclIn), .sdaLine(sdaIn));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		nTests++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task conclude;
		if (failures == 0 && nTests > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task sendByte(input [7:0] b);
		host_u.byteXfer(b, 1'b1, rx, ack);
		check("ack", ack, 1'b1);
	endtask
	task regWrite(input [7:0] ptr);
		host_u.startBit;
		sendByte({BUS_ADDR, 1'b0});
		sendByte(ptr);
		foreach (wrBuf[j]) sendByte(wrBuf[j]);
		host_u.stopBit;
	endtask
	task regRead(input [7:0] ptr, input integer n);
		host_u.startBit;
		sendByte({BUS_ADDR, 1'b0});
		sendByte(ptr);
		host_u.startBit;
		sendByte({BUS_ADDR, 1'b1});
		for (int j = 0; j < n; j++) begin
			host_u.byteXfer(8'hFF, j == n - 1, rdBuf[j], ack);
		end
		host_u.stopBit;
	endtask
	function [13:0] srcV(input [6:0] c);
		if (c >= `HCRB_REG_SAT_CODE) srcV = `HCRB_REG_SAT_VALUE;
		else if (c <= `HCRB_REG_LOW_LAST) srcV = `HCRB_REG_LOW_OFFSET + `HCRB_REG_LOW_STEP * c;
		else srcV = `HCRB_REG_HIGH_STEP * c - `HCRB_REG_HIGH_OFFSET;
	endfunction
	function [18:0] thrV(input [5:0] c, input [18:0] off, input [18:0] floor);
		thrV = off + `HCRB_THR_STEP * c;
		if (thrV < floor) thrV = floor;
	endfunction

	// ----------------------------------------
	// Clock and watchdog
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		#800000;
		failures++;
		conclude;
	end

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		failures = 0;
		nTests = 0;
		rst_n = 1'b0;
		addrStrap = 1'b1;
		eventPulse = 5'h00;
		monitorState = 7'h7F;
		prevSrc = 7'h77;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		check("irqOut", irqOut, 1'b1);
		regRead(8'h00, 20);
		for (i = 0; i < 20; i++) check("reset", rdBuf[i], RST_TAB[8*(19-i)+:8]);
		repeat (4) @(posedge clk);
		check("irqOut", irqOut, 1'b0);
		for (i = 0; i < 7; i++) begin
			cfg = CFG_TAB[24*(6-i)+:24];
			wrBuf = '{cfg[23:16], cfg[15:8], cfg[7:0]};
			regWrite(8'h01);
			check("heldSrc", activeSrcLevel, prevSrc);
			regRead(8'h01, 3);
			check("src", rdBuf[0], cfg[22:16]);
			check("ovdis", rdBuf[1], cfg[13:8]);
			check("ovch", rdBuf[2], cfg[5:0]);
			wrBuf = '{8'h01};
			regWrite(8'h0B);
			repeat (4) @(posedge clk);
			check("activeSrc", activeSrcLevel, cfg[22:16]);
			check("idleState", idleState, cfg[22:16] == 7'h0C);
			check("srcV", srcRegVoltage, srcV(cfg[22:16]));
			check("ovdisV", ovdisVoltage, thrV(cfg[13:8], `HCRB_OVDIS_OFFSET, `HCRB_OVDIS_FLOOR));
			check("ovchV", ovchVoltage, thrV(cfg[5:0], `HCRB_OVCH_OFFSET, `HCRB_OVCH_FLOOR));
			regRead(8'h0B, 1);
			check("apply", rdBuf[0], 8'h00);
			prevSrc = cfg[22:16];
		end
		wrBuf = '{8'h0C, 8'h2D, 8'h33, 8'h5A, 8'hA5, 8'hFD, 8'h00, 8'h04, 8'h0F};
		regWrite(8'h01);
		regRead(8'h06, 1);
		check("power", rdBuf[0], 8'h0D);
		wrBuf = '{8'h01};
		regWrite(8'h0B);
		repeat (4) @(posedge clk);
		check("activeCold", activeCold, 8'h5A);
		check("activeHot", activeHot, 8'hA5);
		check("activePower", activePower, 4'hD);
		check("activeIdleEn", activeIdleEn, 1'b0);
		check("activeRate", activeSampleRate, 3'h4);
		check("activeMeter", activeMeterCtrl, 4'hF);
		check("idleOff", idleState, 1'b0);
		wrBuf = '{8'hFF};
		for (i = 0; i < 6; i++) begin
			regWrite(RO_OFF[8*(5-i)+:8]);
			regRead(RO_OFF[8*(5-i)+:8], 1);
			check("readOnly", rdBuf[0], RO_EXP[8*(5-i)+:8]);
		end
		@(posedge clk) eventPulse <= 5'h04;
		@(posedge clk) eventPulse <= 5'h00;
		repeat (4) @(posedge clk);
		check("maskedIrq", irqOut, 1'b0);
		regRead(8'h0C, 1);
		check("flags", rdBuf[0], 8'h08);
		wrBuf = '{8'h3F};
		regWrite(8'h0A);
		for (k = 1; k < 6; k++) begin
			@(posedge clk) eventPulse <= 5'h01 << (k - 1);
			@(posedge clk) eventPulse <= 5'h00;
			repeat (4) @(posedge clk);
			check("irqOut", irqOut, 1'b1);
			regRead(8'h0C, 1);
			check("flags", rdBuf[0], 8'h01 << k);
			repeat (4) @(posedge clk);
			check("irqOut", irqOut, 1'b0);
		end
		host_u.startBit;
		host_u.byteXfer(8'h80, 1'b1, rx, ack);
		check("wrongAddr", ack, 1'b0);
		host_u.stopBit;
		rst_n <= 1'b0;
		addrStrap <= 1'b0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		check("irqOut", irqOut, 1'b1);
		host_u.startBit;
		host_u.byteXfer({BUS_ADDR, 1'b0}, 1'b1, rx, ack);
		check("oldAddr", ack, 1'b0);
		host_u.stopBit;
		host_u.startBit;
		host_u.byteXfer({`HCRB_BUS_ADDR_BASE, 1'b0}, 1'b1, rx, ack);
		check("strapAddr", ack, 1'b1);
		host_u.stopBit;
		check("sdaOut", sdaOut, 1'b0);
		conclude;
	end
endmodule // hcrb_register_bank_test
